// ### src/pmpc_pkg.sv
// package for the parallel master port control block
package pmpc_pkg;
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] SH_ADDR_OFS   = 8'h04;
  localparam logic [7:0] SH_DATA_OFS   = 8'h08;
  localparam logic [7:0] RD_ADDR_OFS   = 8'h0c;
  localparam logic [7:0] RD_DATA_OFS   = 8'h10;
  localparam logic [7:0] WR_ADDR_OFS   = 8'h14;
  localparam logic [7:0] WR_DATA_OFS   = 8'h18;
  localparam logic [7:0] STATUS_OFS    = 8'h1c;
  localparam int B_LAUNCH = 23;
  localparam int B_SPLIT  = 17;
  localparam int B_ON     = 15;
  localparam int B_HALT   = 13;
  localparam int B_MUX_HI = 12;
  localparam int B_MUX_LO = 11;
  localparam int B_TTL    = 10;
  localparam int B_WREN   = 9;
  localparam int B_RDEN   = 8;
  localparam int B_CSF_HI = 7;
  localparam int B_CSF_LO = 6;
  localparam int B_ALP    = 5;
  localparam int B_SELECT_TWO_POLARITY   = 4;
  localparam int B_SELECT_ONE_POLARITY   = 3;
  localparam int B_WRITE_STROBE_POLARITY   = 1;
  localparam int B_READ_STROBE_POLARITY   = 0;
  localparam logic [31:0] CTRL_WMASK = 32'h0082_bffb;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] MUX_SEP   = 2'h0;
  localparam logic [1:0] MUX_LO8   = 2'h1;
  localparam logic [1:0] MUX_ALL16 = 2'h2;
  localparam logic [1:0] MUX_LO8W  = 2'h3;
  localparam logic [1:0] RESP_OK     = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] STROBE_CYCLES = 3'h2;
  typedef enum logic [1:0] {
    PMPC_IDLE  = 2'b00,
    PMPC_ADDR  = 2'b01,
    PMPC_STRB  = 2'b10,
    PMPC_DONE  = 2'b11
  } pmpc_state_t;
endpackage

// ### src/pmpc_top.sv
// parallel master port control: axi4-lite registers and read cycle engine
// What this block does
// - writing one to bit 23 launches a read; hardware clears it at cycle end
// - bit 17 selects split read/write address and data registers over shared ones
// - bit 15 enables the port; cleared means no off-chip access at all
// - bit 13 set stops the port while the device is idle
// - mux 00 separate pins; 01 low address byte on low data pins
// - mux 10 full address on data pins; 11 low byte on data, upper unused
// - bit 10 picks ttl input thresholds, cleared picks schmitt trigger
// - bit 9 enables the write or enable strobe pin function
// - bit 8 enables the read or read/write strobe pin function
// - select polarity bits ignored on pins used as address lines; latch polarity bit 5 never changes the latch strobe
// - unimplemented control bits read zero and ignore writes
`timescale 1ns/1ps
module pmpc_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        device_idle,
  input  wire logic [15:0] port_data_pins_i,
  output logic [15:0]      port_data_pins_o,
  output logic [15:0]      port_data_pins_oe_b,
  output logic [15:0]      port_address_pins,
  output logic             read_strobe_pin,
  output logic             write_strobe_pin,
  output logic             latch_strobe_pin,
  output logic             chip_select_one_pin,
  output logic             chip_select_two_pin,
  output logic             input_threshold_select
);
  logic [31:0] ctrl_q;
  logic [15:0] sh_addr_q, rd_addr_q, wr_addr_q;
  logic [15:0] sh_data_q, rd_data_q, wr_data_q;
  logic [15:0] din_s1_q, din_s2_q;
  logic        idle_s1_q, idle_s2_q;
  pmpc_pkg::pmpc_state_t st_q;
  logic [2:0]  cnt_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write, done_pulse;
  logic        port_run;
  logic [1:0]  mux;
  logic [15:0] cyc_addr;
  logic        cyc_active, data_take;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // level of a strobe or select pin, given its polarity bit
  function automatic logic pin_level(input logic active, input logic active_high);
    return active_high ? active : ~active;
  endfunction

  assign mux      = ctrl_q[pmpc_pkg::B_MUX_HI:pmpc_pkg::B_MUX_LO];
  assign port_run = ctrl_q[pmpc_pkg::B_ON] & ~(ctrl_q[pmpc_pkg::B_HALT] & idle_s2_q);
  assign cyc_addr = ctrl_q[pmpc_pkg::B_SPLIT] ? rd_addr_q : sh_addr_q;
  assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign done_pulse = (st_q == pmpc_pkg::PMPC_DONE);
  assign cyc_active = (st_q != pmpc_pkg::PMPC_IDLE);
  assign data_take  = done_pulse & ctrl_q[pmpc_pkg::B_ON];

  // input synchronisers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      din_s1_q  <= 16'h0000;
      din_s2_q  <= 16'h0000;
      idle_s1_q <= 1'b0;
      idle_s2_q <= 1'b0;
    end else begin
      din_s1_q  <= port_data_pins_i;
      din_s2_q  <= din_s1_q;
      idle_s1_q <= device_idle;
      idle_s2_q <= idle_s1_q;
    end
  end

  // write address and data capture, either order
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pmpc_pkg::RESP_OK;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[7:2] > pmpc_pkg::STATUS_OFS[7:2]) ? pmpc_pkg::RESP_SLVERR : pmpc_pkg::RESP_OK;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= pmpc_pkg::CTRL_RESET;
    end else begin
      if (do_write && aw_addr_q[7:2] == pmpc_pkg::CTRL_OFS[7:2]) begin
        ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & pmpc_pkg::CTRL_WMASK;
        if (!(w_strb_q[2] & w_data_q[pmpc_pkg::B_LAUNCH])) begin
          ctrl_q[pmpc_pkg::B_LAUNCH] <= ctrl_q[pmpc_pkg::B_LAUNCH] & ~done_pulse;
        end
      end else if (done_pulse) begin
        ctrl_q[pmpc_pkg::B_LAUNCH] <= 1'b0;
      end else if (ctrl_q[pmpc_pkg::B_LAUNCH] && !ctrl_q[pmpc_pkg::B_ON] && st_q == pmpc_pkg::PMPC_IDLE) begin
        ctrl_q[pmpc_pkg::B_LAUNCH] <= 1'b0;
      end
    end
  end

  // address and data registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sh_addr_q <= 16'h0000;
      rd_addr_q <= 16'h0000;
      wr_addr_q <= 16'h0000;
      sh_data_q <= 16'h0000;
      rd_data_q <= 16'h0000;
      wr_data_q <= 16'h0000;
    end else begin
      if (do_write) begin
        unique case (aw_addr_q)
          pmpc_pkg::SH_ADDR_OFS: sh_addr_q <= 16'(merge({16'h0000, sh_addr_q}, w_data_q, w_strb_q));
          pmpc_pkg::RD_ADDR_OFS: rd_addr_q <= 16'(merge({16'h0000, rd_addr_q}, w_data_q, w_strb_q));
          pmpc_pkg::WR_ADDR_OFS: wr_addr_q <= 16'(merge({16'h0000, wr_addr_q}, w_data_q, w_strb_q));
          pmpc_pkg::SH_DATA_OFS: sh_data_q <= 16'(merge({16'h0000, sh_data_q}, w_data_q, w_strb_q));
          pmpc_pkg::WR_DATA_OFS: wr_data_q <= 16'(merge({16'h0000, wr_data_q}, w_data_q, w_strb_q));
          default: ;
        endcase
      end
      // pins seen in the first strobe cycle have cleared both synchroniser stages by now
      if (data_take) begin
        if (ctrl_q[pmpc_pkg::B_SPLIT]) begin
          rd_data_q <= din_s2_q;
        end else begin
          sh_data_q <= din_s2_q;
        end
      end
    end
  end

  // read cycle engine: address phase, strobe phase, done
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= pmpc_pkg::PMPC_IDLE;
      cnt_q <= 3'h0;
    end else begin
      unique case (st_q)
        pmpc_pkg::PMPC_IDLE: begin
          if (ctrl_q[pmpc_pkg::B_LAUNCH] && port_run) begin
            st_q  <= pmpc_pkg::PMPC_ADDR;
            cnt_q <= pmpc_pkg::STROBE_CYCLES;
          end
        end
        pmpc_pkg::PMPC_ADDR: begin
          // port switched off mid-cycle: end it so the launch bit still clears
          if (!ctrl_q[pmpc_pkg::B_ON]) begin
            st_q <= pmpc_pkg::PMPC_DONE;
          end else if (port_run) begin
            st_q <= pmpc_pkg::PMPC_STRB;
          end
        end
        pmpc_pkg::PMPC_STRB: begin
          if (!ctrl_q[pmpc_pkg::B_ON]) begin
            st_q <= pmpc_pkg::PMPC_DONE;
          end else if (port_run) begin
            if (cnt_q == 3'h0) begin
              st_q <= pmpc_pkg::PMPC_DONE;
            end else begin
              cnt_q <= cnt_q - 3'h1;
            end
          end
        end
        pmpc_pkg::PMPC_DONE: st_q <= pmpc_pkg::PMPC_IDLE;
      endcase
    end
  end

  // pin drive
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_data_pins_o       <= 16'h0000;
      port_data_pins_oe_b    <= 16'hffff;
      port_address_pins      <= 16'h0000;
      read_strobe_pin        <= 1'b0;
      write_strobe_pin       <= 1'b0;
      latch_strobe_pin       <= 1'b0;
      chip_select_one_pin    <= 1'b0;
      chip_select_two_pin    <= 1'b0;
      input_threshold_select <= 1'b0;
    end else begin
      input_threshold_select <= ctrl_q[pmpc_pkg::B_TTL];
      port_data_pins_oe_b    <= 16'hffff;
      port_data_pins_o       <= 16'h0000;
      port_address_pins      <= 16'h0000;
      latch_strobe_pin       <= 1'b0;
      if (ctrl_q[pmpc_pkg::B_ON]) begin
        unique case (mux)
          pmpc_pkg::MUX_SEP: port_address_pins <= cyc_addr;
          pmpc_pkg::MUX_LO8: port_address_pins <= {cyc_addr[15:8], 8'h00};
          pmpc_pkg::MUX_ALL16, pmpc_pkg::MUX_LO8W: port_address_pins <= 16'h0000;
        endcase
        if (st_q == pmpc_pkg::PMPC_ADDR && mux != pmpc_pkg::MUX_SEP) begin
          port_data_pins_oe_b <= (mux == pmpc_pkg::MUX_LO8) ? 16'hff00 : 16'h0000;
          unique case (mux)
            pmpc_pkg::MUX_LO8:   port_data_pins_o <= {8'h00, cyc_addr[7:0]};
            pmpc_pkg::MUX_ALL16: port_data_pins_o <= cyc_addr;
            default:             port_data_pins_o <= {8'h00, cyc_addr[7:0]};
          endcase
          latch_strobe_pin <= ctrl_q[pmpc_pkg::B_ALP] | (mux != pmpc_pkg::MUX_SEP);
        end
      end
      // strobe pins driven only when their function is enabled
      read_strobe_pin  <= ctrl_q[pmpc_pkg::B_RDEN] & ctrl_q[pmpc_pkg::B_ON] &
                          pin_level(st_q == pmpc_pkg::PMPC_STRB, ctrl_q[pmpc_pkg::B_READ_STROBE_POLARITY]);
      write_strobe_pin <= ctrl_q[pmpc_pkg::B_WREN] & ctrl_q[pmpc_pkg::B_ON] & ~ctrl_q[pmpc_pkg::B_WRITE_STROBE_POLARITY];
      // select pins take function only when not used as address lines
      chip_select_one_pin <= 1'b0;
      chip_select_two_pin <= 1'b0;
      if (ctrl_q[pmpc_pkg::B_ON] && mux == pmpc_pkg::MUX_SEP) begin
        chip_select_one_pin <= ctrl_q[pmpc_pkg::B_CSF_HI] & pin_level(cyc_active, ctrl_q[pmpc_pkg::B_SELECT_ONE_POLARITY]);
        chip_select_two_pin <= ctrl_q[pmpc_pkg::B_CSF_LO] & pin_level(cyc_active, ctrl_q[pmpc_pkg::B_SELECT_TWO_POLARITY]);
      end
    end
  end

  // read channel
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pmpc_pkg::RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pmpc_pkg::RESP_OK;
        unique case (s_axi_araddr)
          pmpc_pkg::CTRL_OFS:    s_axi_rdata <= ctrl_q & pmpc_pkg::CTRL_WMASK;
          pmpc_pkg::SH_ADDR_OFS: s_axi_rdata <= {16'h0000, sh_addr_q};
          pmpc_pkg::SH_DATA_OFS: s_axi_rdata <= {16'h0000, sh_data_q};
          pmpc_pkg::RD_ADDR_OFS: s_axi_rdata <= {16'h0000, rd_addr_q};
          pmpc_pkg::RD_DATA_OFS: s_axi_rdata <= {16'h0000, rd_data_q};
          pmpc_pkg::WR_ADDR_OFS: s_axi_rdata <= {16'h0000, wr_addr_q};
          pmpc_pkg::WR_DATA_OFS: s_axi_rdata <= {16'h0000, wr_data_q};
          pmpc_pkg::STATUS_OFS:  s_axi_rdata <= {30'h0, idle_s2_q, cyc_active};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pmpc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### tb/pmpc_asserts.sv
// port-level assertions for the parallel master port control block
`timescale 1ns/1ps
module pmpc_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [15:0] port_data_pins_oe_b,
  input wire logic        read_strobe_pin,
  input wire logic        write_strobe_pin,
  input wire logic        chip_select_one_pin,
  input wire logic        chip_select_two_pin,
  input wire logic        input_threshold_select
);
  logic [7:0]  aw_q;
  logic [7:0]  ar_q;
  logic [31:0] sh_q;
  logic [2:0]  st_q;
  logic        ok;
  // addresses of the transfers in flight
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_q <= 8'h00;
      ar_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    end
  end
  // shadow of the control word and cycles since it last changed
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sh_q <= 32'h0000_0000;
      st_q <= 3'h7;
    end else if (s_axi_wvalid && s_axi_wready && s_axi_awaddr == pmpc_pkg::CTRL_OFS) begin
      sh_q <= s_axi_wdata;
      st_q <= 3'h0;
    end else if (st_q != 3'h7) begin
      st_q <= st_q + 3'h1;
    end
  end
  assign ok = (st_q == 3'h7);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_strobe3;
    read_strobe_pin [*3] ##1 !read_strobe_pin;
  endsequence
  sequence s_pins_quiet;
    !read_strobe_pin && !write_strobe_pin && port_data_pins_oe_b == 16'hffff;
  endsequence
  a_strobe_width: assert property ($rose(read_strobe_pin) |-> s_strobe3)
    else $error("read strobe width wrong");
  a_bus_released: assert property (read_strobe_pin |-> port_data_pins_oe_b == 16'hffff)
    else $error("data pins driven during read strobe");
  a_wr_resp: assert property (s_axi_bvalid |-> s_axi_bresp == ((aw_q > 8'h1c) ? 2'h2 : 2'h0))
    else $error("write response code wrong");
  a_rd_resp: assert property (s_axi_rvalid |-> s_axi_rresp == ((ar_q > 8'h1c) ? 2'h2 : 2'h0))
    else $error("read response code wrong");
  a_port_off: assert property (ok && !sh_q[15] |-> s_pins_quiet)
    else $error("pin activity while port off");
  a_ttl_copy: assert property (ok |-> input_threshold_select == sh_q[10])
    else $error("threshold select differs from control");
  a_wr_pin_off: assert property (ok && !sh_q[9] |-> !write_strobe_pin)
    else $error("write strobe active while disabled");
  a_rd_pin_off: assert property (ok && !sh_q[8] |-> !read_strobe_pin)
    else $error("read strobe active while disabled");
  a_csel_mux: assert property (ok && sh_q[12:11] != 2'h0 |-> !chip_select_one_pin && !chip_select_two_pin)
    else $error("chip select active on address pin");
endmodule
bind pmpc_top pmpc_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .port_data_pins_oe_b(port_data_pins_oe_b), .read_strobe_pin(read_strobe_pin),
  .write_strobe_pin(write_strobe_pin), .chip_select_one_pin(chip_select_one_pin),
  .chip_select_two_pin(chip_select_two_pin), .input_threshold_select(input_threshold_select));

// ### tb/pmpc_periph.sv
// behavioural external peripheral answering read strobes
`timescale 1ns/1ps
module pmpc_periph (
  input  wire logic        clk_sys,
  input  wire logic        read_strobe_pin,
  input  wire logic [15:0] reply_data,
  input  wire logic [15:0] port_data_pins_o,
  input  wire logic [15:0] port_data_pins_oe_b,
  output logic      [15:0] port_data_pins_i
);
  logic [15:0] idle_q = 16'h00ff;
  logic [15:0] drive;
  // released bus wanders each cycle so a stale value never looks valid
  always @(posedge clk_sys) begin
    idle_q <= {idle_q[14:0], ~idle_q[15]};
  end
  assign drive = read_strobe_pin ? reply_data : idle_q;
  assign port_data_pins_i = (port_data_pins_oe_b & drive) | (~port_data_pins_oe_b & port_data_pins_o);
endmodule

// ### tb/pmpc_bench.sv
// self-checking bench for the parallel master port control block
`timescale 1ns/1ps
module pmpc_bench;
  logic        clk_sys = 1'b0, rst_b = 1'b0, device_idle = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, strb_q = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] port_data_pins_i, port_data_pins_o, port_data_pins_oe_b, port_address_pins;
  logic [15:0] reply_data = 16'h0, mux_seen, apin_seen;
  logic        read_strobe_pin, write_strobe_pin, latch_strobe_pin;
  logic        chip_select_one_pin, chip_select_two_pin, input_threshold_select;
  int          bad_count = 0, n_tests = 0, cyc = 0, strobes = 0, latches = 0;
  pmpc_top dut (.*);
  pmpc_periph u_periph (.*);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // pin monitor and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (port_data_pins_oe_b != 16'hffff) mux_seen <= port_data_pins_o;
    if (read_strobe_pin) apin_seen <= port_address_pins;
    if (read_strobe_pin && !strb_q) strobes <= strobes + 1;
    strb_q <= read_strobe_pin;
    if (latch_strobe_pin) latches <= latches + 1;
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
  endtask
  initial begin
    logic [31:0] v, d;
    logic [15:0] a, a2;
    v = $urandom(32'h6a1f);
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    axr(pmpc_pkg::CTRL_OFS, d);
    chk(d, 32'h0);
    axw(8'h20, 32'hffff_ffff);
    axr(8'h20, d);
    chk(d, 32'h0);
    repeat (4) begin
      v = $urandom & 32'hff7f_7fff;
      axw(pmpc_pkg::CTRL_OFS, v);
      axr(pmpc_pkg::CTRL_OFS, d);
      chk(d, v & 32'h0082_bffb);
      chk(input_threshold_select, v[10]);
    end
    // idle levels of selects and write strobe, then muxed pins silence the selects
    axw(pmpc_pkg::CTRL_OFS, 32'h0000_82c0);
    repeat (2) @(posedge clk_sys);
    chk({chip_select_one_pin, chip_select_two_pin}, 2'h3);
    chk(write_strobe_pin, 1'b1);
    axw(pmpc_pkg::CTRL_OFS, 32'h0000_8ac0);
    repeat (2) @(posedge clk_sys);
    chk({chip_select_one_pin, chip_select_two_pin}, 2'h0);
    chk(write_strobe_pin, 1'b1);
    axw(pmpc_pkg::CTRL_OFS, 32'h0080_0303);
    repeat (8) @(posedge clk_sys);
    axr(pmpc_pkg::CTRL_OFS, d);
    chk(d, 32'h0000_0303);
    chk(strobes, 0);
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom);
      a2 = 16'($urandom);
      reply_data <= 16'($urandom);
      v = 32'h0080_8303 | {14'h0, i[0], 4'h0, i[2:1], 11'h0};
      axw(pmpc_pkg::SH_ADDR_OFS, {16'h0, a});
      axw(pmpc_pkg::RD_ADDR_OFS, {16'h0, a2});
      axw(pmpc_pkg::CTRL_OFS, v);
      do axr(pmpc_pkg::CTRL_OFS, d); while (d[23] !== 1'b0);
      if (i[0]) a = a2;
      axr(i[0] ? pmpc_pkg::RD_DATA_OFS : pmpc_pkg::SH_DATA_OFS, d);
      chk(d, {16'h0, reply_data});
      chk(strobes, i + 1);
      case (i[2:1])
        2'h0: chk(apin_seen, a);
        2'h1: chk({apin_seen[15:8], mux_seen[7:0]}, a);
        2'h2: chk(mux_seen, a);
        default: chk(mux_seen[7:0], a[7:0]);
      endcase
    end
    chk(latches, 6);
    device_idle <= 1'b1;
    axw(pmpc_pkg::CTRL_OFS, 32'h0080_a303);
    repeat (20) @(posedge clk_sys);
    axr(pmpc_pkg::CTRL_OFS, d);
    chk({d[23], 31'(strobes)}, {1'b1, 31'd8});
    device_idle <= 1'b0;
    do axr(pmpc_pkg::CTRL_OFS, d); while (d[23] !== 1'b0);
    device_idle <= 1'b1;
    axw(pmpc_pkg::CTRL_OFS, 32'h0080_8303);
    repeat (20) @(posedge clk_sys);
    axr(pmpc_pkg::CTRL_OFS, d);
    chk({d[23], 31'(strobes)}, {1'b0, 31'd10});
    device_idle <= 1'b0;
    tally_and_finish();
  end
endmodule
